// [test/tb.sv]
// self-checking bench for the watchdog, interrupt and sleep controller
`timescale 1ns/1ns
module tb;
   import wis_pkg::*;
   localparam int WB = 128;
   localparam logic [15:0] PC0 = 16'h0123;
   localparam int C_WD = 0, C_EN = 1, C_DIS = 2, C_RET = 3, C_SAVE = 4, C_DOWN = 5;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0, lrc_tick_i = 1'b0, fast_boot_i = 1'b0, cpu_ready_i = 1'b0;
   logic comp_event_i = 1'b0, wb_ack_o, mem_we_o, mem_re_o, pc_load_o, cpu_reset_o;
   logic sys_clk_en_o, prog_mem_on_o, osc_run_o, lrc_en_o;
   logic [5:0] cmd = 6'h00, timer_sys_src_i = 6'h00, timer_osc_on_i = 6'h00;
   logic [5:0] timer_match_i = 6'h00, timer_run_o;
   logic [7:0] wb_adr_i = 8'h00, src_i = 8'h00, mem_addr_o;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [15:0] pin_i = 16'h0000, pin_wake_en_i = 16'h0000, pc_i, mem_rdata_i;
   logic [15:0] mem_wdata_o, pc_value_o;
   int err_count = 0, compares = 0, tick_n = 0;
   wis_top #(.WDT_BASE(WB), .NP(16), .NT(6)) i_wis_top (
      .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .lrc_tick_i, .fast_boot_i, .cmd_wdreset_i(cmd[0]),
      .cmd_engint_i(cmd[1]), .cmd_disgint_i(cmd[2]), .cmd_reti_i(cmd[3]),
      .cmd_stopexe_i(cmd[4]), .cmd_stopsys_i(cmd[5]), .cpu_ready_i, .pc_i, .mem_rdata_i,
      .src_i, .pin_i, .pin_wake_en_i, .timer_sys_src_i, .timer_osc_on_i, .timer_match_i,
      .comp_event_i, .mem_we_o, .mem_re_o, .mem_addr_o, .mem_wdata_o, .pc_load_o,
      .pc_value_o, .cpu_reset_o, .sys_clk_en_o, .prog_mem_on_o, .osc_run_o, .lrc_en_o,
      .timer_run_o);
   wis_cpu_model #(.PC_START(PC0)) i_wis_cpu_model (.clk_i, .rst_i, .mem_we_i(mem_we_o),
      .mem_re_i(mem_re_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
      .pc_load_i(pc_load_o), .pc_value_i(pc_value_o), .cpu_reset_i(cpu_reset_o),
      .mem_rdata_o(mem_rdata_i), .pc_o(pc_i));
   initial forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
   // slow ticks exist only while the design keeps the rc oscillator on
   always @(posedge clk_i)
   begin
      lrc_tick_i <= (lrc_en_o === 1'b1) && !lrc_tick_i;
      tick_n <= tick_n + int'(lrc_tick_i);
   end
   task automatic close_out;
      if (err_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task automatic cmp_rng(input string nm, input int lo, input int hi, input int g);
      compares++;
      if (g < lo || g > hi)
      begin
         err_count++;
         $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask : cmp_rng
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1);
      cmp("bus ack wait", 32'h2, n);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      cmp(nm, e, rd);
   endtask : rchk
   task automatic pulse(input int c);
      cmd[c] <= 1'b1;
      @(posedge clk_i);
      cmd <= 6'h00;
      @(posedge clk_i);
   endtask : pulse
   function automatic logic sv(input int w);
      case (w)
         0: return mem_we_o;
         1: return pc_load_o;
         2: return cpu_reset_o;
         default: return sys_clk_en_o;
      endcase
   endfunction : sv
   task automatic wait_on(input int w, input int lim);
      int n;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (sv(w) !== 1'b1 && n < lim);
      cmp("awaited pulse", 32'h1, {31'h0, sv(w)});
   endtask : wait_on
   task automatic do_reset(input logic fb);
      fast_boot_i <= fb;
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      pulse(C_WD);
   endtask : do_reset
   task automatic poke(input logic [5:0] tm, input logic ce, input logic [15:0] pn);
      timer_match_i <= tm;
      comp_event_i <= ce;
      pin_i <= pin_i ^ pn;
      @(posedge clk_i);
      timer_match_i <= 6'h00;
      comp_event_i <= 1'b0;
   endtask : poke
   task automatic asleep(input logic [1:0] e);
      repeat (120) @(posedge clk_i);
      cmp("still asleep", e, {sys_clk_en_o, lrc_en_o});
   endtask : asleep
   task automatic sleep_in(input int c, input logic [3:0] lv);
      pulse(c);
      repeat (2) @(posedge clk_i);
      cmp("sleep levels", lv, {sys_clk_en_o, prog_mem_on_o, osc_run_o, lrc_en_o});
   endtask : sleep_in
   task automatic wake_time(input int e);
      int t0;
      t0 = tick_n;
      wait_on(3, 20000);
      cmp_rng("wake ticks", e - 2, e + 2, tick_n - t0);
      repeat (2) @(posedge clk_i);
      cmp("awake levels", 32'hF, {sys_clk_en_o, prog_mem_on_o, osc_run_o, lrc_en_o});
      cmp("pc kept", PC0, pc_i);
   endtask : wake_time
   task automatic t_regs;
      rchk("aux reset", REG_AUX_CTRL, 32'h0);
      rchk("status reset", REG_STATUS, 32'h0);
      ce_i <= 1'b0;
      pulse(C_EN);
      ce_i <= 1'b1;
      rchk("frozen command", REG_STATUS, 32'h0);
      wb(1'b1, REG_STACK_PTR, 32'h21);
      rchk("sp even", REG_STACK_PTR, 32'h20);
      wb(1'b1, 8'h40, 32'hFF);
      rchk("unmapped", 8'h40, 32'h0);
   endtask : t_regs
   task automatic t_edges;
      logic [1:0] m [3] = '{EDGE_RISE, EDGE_FALL, 2'h0};
      wb(1'b1, REG_INT_EN, 32'h0);
      wb(1'b1, REG_INT_REQ, 32'h0);
      src_i[7:2] <= 6'h3F;
      repeat (3) @(posedge clk_i);
      rchk("flags disabled", REG_INT_REQ, 32'hFC);
      rchk("flags held", REG_INT_REQ, 32'hFC);
      wb(1'b1, REG_INT_REQ, 32'hF3);
      rchk("partial clear", REG_INT_REQ, 32'hF0);
      src_i[7:2] <= 6'h00;
      for (int j = 0; j < 2; j++)
         for (int i = 0; i < 3; i++)
         begin
            wb(1'b1, REG_EDGE_SEL, 32'(m[i]) << (2 * j));
            wb(1'b1, REG_INT_REQ, 32'h0);
            src_i[j] <= 1'b1;
            repeat (3) @(posedge clk_i);
            rchk("rise flag", REG_INT_REQ, 32'(m[i] != EDGE_FALL) << j);
            wb(1'b1, REG_INT_REQ, 32'h0);
            src_i[j] <= 1'b0;
            repeat (3) @(posedge clk_i);
            rchk("fall flag", REG_INT_REQ, 32'(m[i] != EDGE_RISE) << j);
         end
      wb(1'b1, REG_INT_REQ, 32'h0);
   endtask : t_edges
   task automatic t_irq;
      pulse(C_WD);
      wb(1'b1, REG_STACK_PTR, 32'h20);
      wb(1'b1, REG_INT_EN, 32'h04);
      cpu_ready_i <= 1'b1;
      src_i[2] <= 1'b1;
      repeat (20) @(posedge clk_i);
      cmp("no take gie off", PC0, pc_i);
      pulse(C_EN);
      wait_on(0, 20);
      cmp("push addr", 32'h20, mem_addr_o);
      cmp("push pc", PC0, mem_wdata_o);
      cmp("vector", INT_VECTOR, pc_value_o);
      src_i[2] <= 1'b0;
      wb(1'b1, REG_INT_REQ, 32'h0);
      rchk("sp plus two", REG_STACK_PTR, 32'h22);
      rchk("gie cleared", REG_STATUS, 32'h0);
      pulse(C_RET);
      wait_on(1, 20);
      cmp("return pc", PC0, pc_value_o);
      rchk("sp minus two", REG_STACK_PTR, 32'h20);
      rchk("gie set", REG_STATUS, 32'h2);
      pulse(C_DIS);
      rchk("gie off by command", REG_STATUS, 32'h0);
      cpu_ready_i <= 1'b0;
   endtask : t_irq
   task automatic t_sleep;
      timer_sys_src_i <= 6'h01;
      timer_osc_on_i <= 6'h3D;
      pin_wake_en_i <= 16'h0001;
      wb(1'b1, REG_AUX_CTRL, 32'h23);
      wb(1'b1, REG_COMP_CTRL, 32'h80);
      wb(1'b1, REG_COMP_SEL, 32'h00);
      pulse(C_WD);
      sleep_in(C_SAVE, 4'b0011);
      cmp("timers run", 32'h3C, timer_run_o);
      poke(6'h01, 1'b1, 16'h0002);
      asleep(2'b01);
      poke(6'h04, 1'b0, 16'h0);
      wake_time(WAKE_FAST_TICKS);
      wb(1'b1, REG_COMP_SEL, 32'h40);
      sleep_in(C_SAVE, 4'b0011);
      poke(6'h00, 1'b1, 16'h0);
      wake_time(WAKE_FAST_TICKS);
      wb(1'b1, REG_COMP_CTRL, 32'h00);
      wb(1'b1, REG_AUX_CTRL, 32'h03);
      pulse(C_WD);
      sleep_in(C_DOWN, 4'b0000);
      poke(6'h04, 1'b0, 16'h0002);
      asleep(2'b00);
      poke(6'h00, 1'b0, 16'h0001);
      wake_time(WAKE_NORMAL_TICKS);
   endtask : t_sleep
   task automatic t_wdt;
      int mul [4] = '{1, WDT_MUL_16K, WDT_MUL_64K, WDT_MUL_256K};
      int t0;
      for (int s = 0; s < 4; s++)
      begin
         wb(1'b1, REG_AUX_CTRL, 32'(s));
         wb(1'b1, REG_INT_EN, 32'h5A);
         repeat (WB) @(posedge clk_i);
         pulse(C_WD);
         t0 = tick_n;
         wait_on(2, 70000);
         cmp_rng("wdt ticks", WB * mul[s] - 2, WB * mul[s] + 2, tick_n - t0);
         rchk("aux after wdt", REG_AUX_CTRL, 32'h0);
         rchk("enables after wdt", REG_INT_EN, 32'h0);
         cmp("restart pc", 32'h0, pc_i);
         pulse(C_WD);
      end
   endtask : t_wdt
   task automatic t_fast;
      do_reset(1'b1);
      rchk("strap", REG_STATUS, 32'h1);
      wb(1'b1, REG_AUX_CTRL, 32'h03);
      pulse(C_WD);
      sleep_in(C_SAVE, 4'b0011);
      poke(6'h00, 1'b0, 16'h0001);
      wake_time(WAKE_FAST_TICKS);
   endtask : t_fast
   initial
   begin
      do_reset(1'b0);
      t_regs;
      t_edges;
      t_irq;
      t_sleep;
      t_wdt;
      t_fast;
      close_out;
   end
   // budget covers the long watchdog and normal wake-up waits with margin
   initial
   begin
      repeat (90000) @(posedge clk_i);
      err_count++;
      close_out;
   end
endmodule : tb

// [test/wis_cpu_model.sv]
// behavioural cpu core model: stack memory and program counter
`timescale 1ns/1ns
module wis_cpu_model
   import wis_pkg::*;
#(
   parameter logic [15:0] PC_START = 16'h0123
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic mem_we_i,
   input wire logic mem_re_i,
   input wire logic [7:0] mem_addr_i,
   input wire logic [15:0] mem_wdata_i,
   input wire logic pc_load_i,
   input wire logic [15:0] pc_value_i,
   input wire logic cpu_reset_i,
   output logic [15:0] mem_rdata_o,
   output logic [15:0] pc_o
);
   // whole page kept free for the stack, two bytes a nesting level
   logic [7:0] ram [0:255];
   always_ff @(posedge clk_i)
   begin
      if (mem_we_i)
      begin
         ram[mem_addr_i] <= mem_wdata_i[7:0];
         ram[mem_addr_i + 8'h01] <= mem_wdata_i[15:8];
      end
      // outside the read slot the lines carry no word, so they keep changing
      if (rst_i)
         mem_rdata_o <= 16'h0000;
      else
         mem_rdata_o <= mem_re_i ? {ram[mem_addr_i + 8'h01], ram[mem_addr_i]} : ~mem_rdata_o;
      if (rst_i)
         pc_o <= PC_START;
      else if (cpu_reset_i)
         pc_o <= 16'h0000;
      else if (pc_load_i)
         pc_o <= pc_value_i;
   end
endmodule : wis_cpu_model

// [verilog/wis_pkg.sv]
// constants, encodings and state types of the watchdog, interrupt and sleep controller
// How it works
// - watchdog counts low-speed RC ticks; reset or clear command zeroes it anytime
// - two-bit timeout select: 8k, 16k, 64k, 256k ticks; resets to 00
// - reaching the selected timeout resets the device and restarts the program
// - eight interrupt sources, each with its own enable bit
// - hardware sets request flags; software clears by writing; flags hold until written
// - edge select picks rising, falling or both edges for the pin sources
// - global enable gates all lines; enable and disable commands set and clear it
// - request flags set even when a source is disabled; only dispatch is held off
// - interrupt entry pushes pc at stack pointer, adds two, clears enable, jumps 0x010
// - return pops pc, subtracts two, sets global enable, resumes interrupted code
// - saved pc is sixteen bits in two bytes; stack pointer bit 0 stays zero
// - power-save stops only the system clock; oscillators run; program memory off
// - in power-save a timer stops if on system clock or a stopped oscillator
// - power-save wakes on enabled pin toggle or match of a non-system-clock timer on a running oscillator
// - power-save wakes on comparator only with control bit 7 and select bit 6
// - low-speed RC stays on in power-save and wake-up runs from it
// - power-down stops all oscillators, keeps state, wakes only on pin toggle
// - timer wake-up only in power-save, never in power-down
// - wake-up lasts 3000 RC ticks normally or 45 RC ticks in fast mode
// - fast boot forces fast wake-up; otherwise aux control bit 5 decides
// - pin wake-up continues after the sleep command with no reset
package wis_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // wishbone byte offsets
   localparam logic [7:0] REG_AUX_CTRL = 8'h00;
   localparam logic [7:0] REG_INT_EN = 8'h04;
   localparam logic [7:0] REG_INT_REQ = 8'h08;
   localparam logic [7:0] REG_EDGE_SEL = 8'h0C;
   localparam logic [7:0] REG_STACK_PTR = 8'h10;
   localparam logic [7:0] REG_COMP_CTRL = 8'h14;
   localparam logic [7:0] REG_COMP_SEL = 8'h18;
   localparam logic [7:0] REG_STATUS = 8'h1C;
   // field positions and reset values
   localparam int AUX_WDT_SEL_LSB = 0;
   localparam int AUX_FAST_WAKE_BIT = 5;
   localparam int COMP_CTRL_EN_BIT = 7;
   localparam int COMP_SEL_WAKE_BIT = 6;
   localparam logic [1:0] WDT_SEL_RST = 2'h0;
   localparam logic [7:0] REG8_RST = 8'h00;
   // watchdog timeouts in RC ticks, binary multiples of the base
   localparam int WDT_BASE_TICKS = 32'h0000_2000;
   localparam int WDT_MUL_16K = 2;
   localparam int WDT_MUL_64K = 8;
   localparam int WDT_MUL_256K = 32;
   // wake-up delays in RC ticks
   localparam logic [11:0] WAKE_NORMAL_TICKS = 12'hBB8;
   localparam logic [11:0] WAKE_FAST_TICKS = 12'h02D;
   // interrupt vector and source layout
   localparam logic [15:0] INT_VECTOR = 16'h0010;
   localparam logic [7:0] SP_STEP = 8'h02;
   localparam int INT_SRC_COUNT = 8;
   localparam int EXT_SRC_COUNT = 2;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam int PIN_COUNT = 16;
   localparam int TIMER_COUNT = 6;
   typedef enum logic [1:0] {M_RUN, M_SAVE, M_DOWN, M_WAKE} wis_mode_t;
   typedef enum logic [1:0] {I_IDLE, I_RD, I_LOAD} wis_istate_t;
endpackage : wis_pkg

// [verilog/wis_top.sv]
// watchdog, interrupt controller and sleep sequencer with a wishbone register port
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
module wis_top
   import wis_pkg::*;
#(
   parameter int WDT_BASE = WDT_BASE_TICKS,
   parameter int NP = PIN_COUNT,
   parameter int NT = TIMER_COUNT
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic lrc_tick_i,
   input wire logic fast_boot_i,
   input wire logic cmd_wdreset_i,
   input wire logic cmd_engint_i,
   input wire logic cmd_disgint_i,
   input wire logic cmd_reti_i,
   input wire logic cmd_stopexe_i,
   input wire logic cmd_stopsys_i,
   input wire logic cpu_ready_i,
   input wire logic [15:0] pc_i,
   input wire logic [15:0] mem_rdata_i,
   input wire logic [INT_SRC_COUNT-1:0] src_i,
   input wire logic [NP-1:0] pin_i,
   input wire logic [NP-1:0] pin_wake_en_i,
   input wire logic [NT-1:0] timer_sys_src_i,
   input wire logic [NT-1:0] timer_osc_on_i,
   input wire logic [NT-1:0] timer_match_i,
   input wire logic comp_event_i,
   output logic mem_we_o,
   output logic mem_re_o,
   output logic [7:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   output logic pc_load_o,
   output logic [15:0] pc_value_o,
   output logic cpu_reset_o,
   output logic sys_clk_en_o,
   output logic prog_mem_on_o,
   output logic osc_run_o,
   output logic lrc_en_o,
   output logic [NT-1:0] timer_run_o
);
   localparam int WDT_W = $clog2(WDT_BASE * WDT_MUL_256K + 1);

   typedef struct packed {
      wis_mode_t mode;
      wis_istate_t istate;
      logic [WDT_W-1:0] wdt_cnt;
      logic [11:0] wake_cnt;
      logic [1:0] wdt_sel;
      logic fast_wake;
      logic [7:0] int_en;
      logic [7:0] int_req;
      logic [3:0] edge_sel;
      logic [7:0] stack_ptr;
      logic [7:0] comp_ctrl;
      logic [7:0] comp_sel;
      logic gie;
      logic fast_boot;
      logic boot_seen;
      logic [INT_SRC_COUNT-1:0] src_prev;
      logic [NP-1:0] pin_prev;
      logic [31:0] dat;
      logic ack;
      logic mem_we;
      logic mem_re;
      logic [7:0] mem_addr;
      logic [15:0] mem_wdata;
      logic pc_load;
      logic [15:0] pc_value;
      logic cpu_reset;
      logic sys_clk_en;
      logic prog_mem_on;
      logic osc_run;
      logic lrc_en;
      logic [NT-1:0] timer_run;
   } wis_state_t;

   wis_state_t st;
   wis_state_t next_st;
   logic [INT_SRC_COUNT-1:0] set_ev;
   logic [WDT_W-1:0] wdt_limit;
   logic [11:0] wake_limit;
   logic bus_req;
   logic bus_wr;
   logic take;
   logic wdt_fire;
   logic wake_any;
   logic [NT-1:0] timer_free;

   // per-source flag set; flags do not look at the enables
   for (genvar g = 0; g < INT_SRC_COUNT; g++)
   begin : g_src
      logic rise;
      logic fall;
      // no edge in the first cycle after reset, the old level is not known yet
      assign rise = st.boot_seen & src_i[g] & ~st.src_prev[g];
      assign fall = st.boot_seen & ~src_i[g] & st.src_prev[g];
      if (g < EXT_SRC_COUNT)
      begin : g_ext
         logic [1:0] es;
         assign es = st.edge_sel[2*g +: 2];
         assign set_ev[g] = (rise & (es != EDGE_FALL)) | (fall & (es != EDGE_RISE));
      end
      else
      begin : g_int
         assign set_ev[g] = rise;
      end
   end

   always_comb
   begin
      next_st = st;
      next_st.ack = 1'b0;
      next_st.mem_we = 1'b0;
      next_st.mem_re = 1'b0;
      next_st.pc_load = 1'b0;
      next_st.cpu_reset = 1'b0;
      next_st.src_prev = src_i;
      next_st.pin_prev = pin_i;
      // strap is caught after reset release, never by the reset itself
      if (!st.boot_seen)
      begin
         next_st.fast_boot = fast_boot_i;
         next_st.boot_seen = 1'b1;
      end
      unique case (st.wdt_sel)
         2'h0: wdt_limit = WDT_W'(WDT_BASE);
         2'h1: wdt_limit = WDT_W'(WDT_BASE * WDT_MUL_16K);
         2'h2: wdt_limit = WDT_W'(WDT_BASE * WDT_MUL_64K);
         2'h3: wdt_limit = WDT_W'(WDT_BASE * WDT_MUL_256K);
      endcase
      wake_limit = (st.fast_boot | st.fast_wake) ? WAKE_FAST_TICKS : WAKE_NORMAL_TICKS;
      timer_free = ~timer_sys_src_i & timer_osc_on_i;
      // register port: one wait state, ack dropped the cycle after
      bus_req = wb_cyc_i & wb_stb_i & ~st.ack;
      bus_wr = bus_req & wb_we_i & wb_sel_i[0];
      if (bus_req)
      begin
         next_st.ack = 1'b1;
         next_st.dat = 32'h0000_0000;
         unique case (wb_adr_i)
            REG_AUX_CTRL: next_st.dat[7:0] = {2'h0, st.fast_wake, 3'h0, st.wdt_sel};
            REG_INT_EN: next_st.dat[7:0] = st.int_en;
            REG_INT_REQ: next_st.dat[7:0] = st.int_req;
            REG_EDGE_SEL: next_st.dat[3:0] = st.edge_sel;
            REG_STACK_PTR: next_st.dat[7:0] = st.stack_ptr;
            REG_COMP_CTRL: next_st.dat[7:0] = st.comp_ctrl;
            REG_COMP_SEL: next_st.dat[7:0] = st.comp_sel;
            REG_STATUS: next_st.dat[5:0] = {st.istate, st.mode, st.gie, st.fast_boot};
            default: next_st.dat = 32'h0000_0000;
         endcase
      end
      if (bus_wr)
      begin
         unique case (wb_adr_i)
            REG_AUX_CTRL:
            begin
               next_st.wdt_sel = wb_dat_i[AUX_WDT_SEL_LSB +: 2];
               next_st.fast_wake = wb_dat_i[AUX_FAST_WAKE_BIT];
            end
            REG_INT_EN: next_st.int_en = wb_dat_i[7:0];
            REG_INT_REQ: next_st.int_req = st.int_req & wb_dat_i[7:0];
            REG_EDGE_SEL: next_st.edge_sel = wb_dat_i[3:0];
            REG_STACK_PTR: next_st.stack_ptr = {wb_dat_i[7:1], 1'b0};
            REG_COMP_CTRL: next_st.comp_ctrl = wb_dat_i[7:0];
            REG_COMP_SEL: next_st.comp_sel = wb_dat_i[7:0];
            default: next_st.dat = 32'h0000_0000;
         endcase
      end
      // a fresh event beats a clear in the same cycle
      next_st.int_req = next_st.int_req | set_ev;
      // cpu side of the interrupt controller
      take = 1'b0;
      if (st.mode == M_RUN)
      begin
         unique case (st.istate)
            I_IDLE:
            begin
               if (cmd_reti_i)
               begin
                  next_st.mem_re = 1'b1;
                  next_st.mem_addr = st.stack_ptr - SP_STEP;
                  next_st.istate = I_RD;
               end
               else if (cpu_ready_i && st.gie && |(st.int_req & st.int_en))
               begin
                  take = 1'b1;
                  next_st.mem_we = 1'b1;
                  next_st.mem_addr = st.stack_ptr;
                  next_st.mem_wdata = pc_i;
                  next_st.stack_ptr = st.stack_ptr + SP_STEP;
                  next_st.gie = 1'b0;
                  next_st.pc_load = 1'b1;
                  next_st.pc_value = INT_VECTOR;
               end
               else if (cmd_engint_i)
               begin
                  next_st.gie = 1'b1;
               end
               else if (cmd_disgint_i)
               begin
                  next_st.gie = 1'b0;
               end
               else if (cmd_stopexe_i)
               begin
                  next_st.mode = M_SAVE;
               end
               else if (cmd_stopsys_i)
               begin
                  next_st.mode = M_DOWN;
               end
            end
            I_RD: next_st.istate = I_LOAD;
            I_LOAD:
            begin
               next_st.pc_load = 1'b1;
               next_st.pc_value = mem_rdata_i;
               next_st.stack_ptr = st.stack_ptr - SP_STEP;
               next_st.gie = 1'b1;
               next_st.istate = I_IDLE;
            end
            default: next_st.istate = I_IDLE;
         endcase
      end
      // sleep and wake sequencing
      wake_any = 1'b0;
      unique case (st.mode)
         M_SAVE:
         begin
            wake_any = |((pin_i ^ st.pin_prev) & pin_wake_en_i)
               | |(timer_match_i & timer_free)
               | (comp_event_i & st.comp_ctrl[COMP_CTRL_EN_BIT]
                  & st.comp_sel[COMP_SEL_WAKE_BIT]);
         end
         M_DOWN: wake_any = |((pin_i ^ st.pin_prev) & pin_wake_en_i);
         M_WAKE:
         begin
            if (lrc_tick_i)
            begin
               if (st.wake_cnt == wake_limit - 12'h001)
               begin
                  next_st.mode = M_RUN;
               end
               else
               begin
                  next_st.wake_cnt = st.wake_cnt + 12'h001;
               end
            end
         end
         M_RUN: wake_any = 1'b0;
      endcase
      if (wake_any)
      begin
         // wake resumes after the sleep command; nothing is reset
         next_st.mode = M_WAKE;
         next_st.wake_cnt = 12'h000;
      end
      // watchdog runs only while the RC oscillator does
      wdt_fire = 1'b0;
      if (cmd_wdreset_i)
      begin
         next_st.wdt_cnt = '0;
      end
      else if (lrc_tick_i && st.lrc_en)
      begin
         // a select cut below the count fires at once instead of wrapping
         if (st.wdt_cnt >= wdt_limit - WDT_W'(1))
         begin
            wdt_fire = 1'b1;
         end
         else
         begin
            next_st.wdt_cnt = st.wdt_cnt + WDT_W'(1);
         end
      end
      if (wdt_fire)
      begin
         // timeout acts as a device reset; straps are kept
         next_st.wdt_cnt = '0;
         next_st.cpu_reset = 1'b1;
         next_st.mode = M_RUN;
         next_st.istate = I_IDLE;
         next_st.wdt_sel = WDT_SEL_RST;
         next_st.fast_wake = 1'b0;
         next_st.int_en = REG8_RST;
         next_st.int_req = REG8_RST;
         next_st.edge_sel = 4'h0;
         next_st.stack_ptr = REG8_RST;
         next_st.comp_ctrl = REG8_RST;
         next_st.comp_sel = REG8_RST;
         next_st.gie = 1'b0;
         next_st.mem_we = 1'b0;
         next_st.mem_re = 1'b0;
         next_st.pc_load = 1'b0;
      end
      // power controls, registered from the next mode
      next_st.sys_clk_en = (next_st.mode == M_RUN);
      next_st.prog_mem_on = (next_st.mode == M_RUN);
      next_st.osc_run = (next_st.mode != M_DOWN);
      next_st.lrc_en = (next_st.mode != M_DOWN);
      next_st.timer_run = (next_st.mode == M_RUN) ? {NT{1'b1}}
         : (next_st.mode == M_SAVE) ? timer_free : {NT{1'b0}};
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st <= '0;
         st.mode <= M_RUN;
         st.istate <= I_IDLE;
         st.sys_clk_en <= 1'b1;
         st.prog_mem_on <= 1'b1;
         st.osc_run <= 1'b1;
         st.lrc_en <= 1'b1;
         st.timer_run <= {NT{1'b1}};
      end
      else if (ce_i)
      begin
         st <= next_st;
      end
   end

   assign wb_dat_o = st.dat;
   assign wb_ack_o = st.ack;
   assign mem_we_o = st.mem_we;
   assign mem_re_o = st.mem_re;
   assign mem_addr_o = st.mem_addr;
   assign mem_wdata_o = st.mem_wdata;
   assign pc_load_o = st.pc_load;
   assign pc_value_o = st.pc_value;
   assign cpu_reset_o = st.cpu_reset;
   assign sys_clk_en_o = st.sys_clk_en;
   assign prog_mem_on_o = st.prog_mem_on;
   assign osc_run_o = st.osc_run;
   assign lrc_en_o = st.lrc_en;
   assign timer_run_o = st.timer_run;

   // checks, suspended while frozen or in reset
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i || !ce_i);

   sequence s_reti_start;
      mem_re_o && mem_addr_o == $past(st.stack_ptr) - SP_STEP;
   endsequence
   sequence s_reti_load;
      !mem_re_o ##1 pc_load_o && st.gie && pc_value_o == $past(mem_rdata_i);
   endsequence

   a_wdt_clear_now: assert property (cmd_wdreset_i |=> st.wdt_cnt == '0)
      else $error("watchdog not cleared by clear command");
   a_wdt_fire_reset: assert property (wdt_fire |=> cpu_reset_o && st.int_en == REG8_RST)
      else $error("watchdog timeout did not reset");
   a_wdt_limit_held: assert property (lrc_tick_i && st.lrc_en && !cmd_wdreset_i
      && st.wdt_cnt >= wdt_limit - WDT_W'(1) |=> cpu_reset_o)
      else $error("watchdog counter passed its limit");
   a_take_vector: assert property (take && !wdt_fire |=> pc_load_o && pc_value_o == INT_VECTOR
      && mem_we_o && !st.gie && st.stack_ptr == $past(st.stack_ptr) + SP_STEP)
      else $error("interrupt entry wrong");
   a_reti_order: assert property (cmd_reti_i && st.istate == I_IDLE && st.mode == M_RUN
      && !wdt_fire |=> s_reti_start ##1 s_reti_load)
      else $error("return sequence wrong");
   a_flag_set_wins: assert property (set_ev[2] && !wdt_fire |=> st.int_req[2])
      else $error("request flag lost");
   a_sp_aligned: assert property (!st.stack_ptr[0])
      else $error("stack pointer misaligned");
   a_save_clocks: assert property (st.mode == M_SAVE |-> !sys_clk_en_o && osc_run_o
      && lrc_en_o && !prog_mem_on_o)
      else $error("power-save clock state wrong");
   a_down_stop: assert property (st.mode == M_DOWN |-> !osc_run_o && !lrc_en_o)
      else $error("power-down oscillators running");
   a_wake_bound: assert property (st.mode == M_WAKE |-> st.wake_cnt < wake_limit)
      else $error("wake counter passed its limit");
endmodule : wis_top
